// ==== rtl/fsc_cell_ctrl.sv ====
// slip reduction extra charge pump cell stepper
`timescale 1ns/1ps
module fsc_cell_ctrl
   import fsc_pkg::*;
#(
   parameter int CELLS = 7
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // control
   input  wire logic              enable,
   input  wire logic              cmp_tick,
   input  wire logic              slip_near,
   input  wire logic              slip_up,
   input  wire logic              passed_target,
   // state
   output logic [CELL_W-1:0]      cells_q,
   output logic                   dir_up_q
);

   // the pump has no more than seven extra cells to switch
   if (CELLS < 1 || CELLS > int'(CELL_MAX))
   begin : g_bad_cells
      $error("CELLS must be 1..7");
   end

   logic          down_q;
   logic [CELL_W-1:0] cells_d;
   wire  logic    at_max = (cells_q == CELL_W'(CELLS));
   wire  logic    step_up   = enable && cmp_tick && slip_near && !down_q && !at_max;
   wire  logic    step_down = cmp_tick && (down_q || !enable) && (cells_q != '0);

   // step up on each near-slip, step down one by one after overshoot
   always_comb
   begin
      cells_d = cells_q;
      if (step_up)        cells_d = cells_q + CELL_W'(1);
      else if (step_down) cells_d = cells_q - CELL_W'(1);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cells_q  <= '0;
         dir_up_q <= 1'b0;
         down_q   <= 1'b0;
      end
      else
      begin
         cells_q <= cells_d;
         if (step_up && cells_q == '0) dir_up_q <= slip_up;
         if (enable && passed_target && cells_q != '0) down_q <= 1'b1;
         else if (cells_q == '0) down_q <= 1'b0;
      end
   end

   property p_cell_max;
      @(posedge clk) disable iff (!rstn) cells_q <= CELL_W'(CELLS);
   endproperty
   a_cell_max: assert property (p_cell_max) else $error("too many cells");

   property p_cell_down;
      @(posedge clk) disable iff (!rstn)
      (down_q && cmp_tick && cells_q != '0) |=> (cells_q == $past(cells_q) - CELL_W'(1));
   endproperty
   a_cell_down: assert property (p_cell_down) else $error("cell not released");

endmodule : fsc_cell_ctrl

// ==== rtl/fsc_ctrl.sv ====
// fractional synthesizer register decode, slip reduction and fastlock timer
`timescale 1ns/1ps
// Functional notes
// - output equals rate times int plus fraction
// - rate from doubler, r count, half stage
// - fraction is high shifted thirteen plus low
// - near slip switches on one extra cell
// - further slips add cells, seven at most
// - after overshoot cells drop one by one
// - slip reduction only with enable bit set
// - fastlock mode takes timer from divider field
// - wide bandwidth lasts timer comparison cycles
// - wide bandwidth raises pump current sixteenfold
// - fastlock mux select grounds mux output pin during wide bandwidth
// - low three bits select destination register
module fsc_ctrl
   import fsc_pkg::*;
#(
   parameter int CELLS = 7
)
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // latched serial word
   input  wire logic [WORD_W-1:0]    wr_data,
   input  wire logic                 wr_strobe,
   // loop events, one clk each, tick once per comparison cycle
   input  wire logic                 cmp_tick,
   input  wire logic                 slip_near,
   input  wire logic                 slip_up,
   input  wire logic                 passed_target,
   // divider settings
   output logic [INT_W-1:0]          int_value_q,
   output logic [FRACTION_WORD_W-1:0]         fraction_word_q,
   output logic                      ref_double_q,
   output logic [RCNT_W-1:0]         r_count_q,
   output logic                      ref_half_q,
   output logic                      polarity_pos_q,
   // charge pump
   output logic [CPO_W-1:0]          cp_current_q,
   output logic                      wide_bw_q,
   output logic                      cycle_slip_reduce_en_q,
   output logic [CELL_W-1:0]         extra_cells_q,
   output logic                      extra_dir_up_q,
   // mux pin, open drain to ground
   output logic [MUX_W-1:0]          mux_sel_q,
   output logic                      mux_output_pin_o_q,
   output logic                      mux_output_pin_oe_q
);

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire logic [CTL_W-1:0] ctl = wr_data[CTL_W-1:0];
   wire logic wr_int  = wr_strobe && (ctl == CTL_INTFRAC);
   wire logic wr_lsb  = wr_strobe && (ctl == CTL_LSBFRAC);
   wire logic wr_rdiv = wr_strobe && (ctl == CTL_RDIV);
   wire logic wr_func = wr_strobe && (ctl == CTL_FUNC);
   wire logic wr_test = wr_strobe && (ctl == CTL_TEST);

   logic [FHI_W-1:0]  fraction_word_hi_q;
   logic [FLO_W-1:0]  fraction_word_lo_q;
   logic [CP_W-1:0]   cp_set_q;
   logic [MODE_W-1:0] clk_mode_q;
   logic [TMR_W-1:0]  timer_val_q;
   logic [TMR_W-1:0]  fl_cnt_q;
   fsc_fl_e           fl_q;

   // int * 2^25 + fraction_word gives N * 2^25; rate = ref*(1+D)/(R*(1+T))
   wire logic [FRACTION_WORD_W-1:0] fraction_word_d = {fraction_word_hi_q, fraction_word_lo_q};
   wire logic fl_mode = (clk_mode_q == MODE_FASTLOCK);
   wire logic fl_pin  = fl_mode && (mux_sel_q == MUX_FASTLOCK) && (fl_q == FL_WIDE);
   wire logic [CPO_W-1:0] cp_base = CPO_W'(cp_set_q) + CPO_W'(1);
   wire logic [CPO_W-1:0] cp_d = (fl_q == FL_WIDE) ? CPO_W'(cp_base << CP_GAIN_SH)
                                                    : cp_base;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         int_value_q    <= '0;
         fraction_word_hi_q      <= '0;
         fraction_word_lo_q      <= '0;
         mux_sel_q      <= '0;
         cp_set_q       <= '0;
         ref_double_q   <= 1'b0;
         ref_half_q     <= 1'b0;
         r_count_q      <= '0;
         cycle_slip_reduce_en_q <= 1'b0;
         polarity_pos_q <= 1'b0;
         clk_mode_q     <= '0;
         timer_val_q    <= '0;
      end
      else
      begin
         if (wr_int)
         begin
            mux_sel_q   <= wr_data[MUX_LSB +: MUX_W];
            int_value_q <= wr_data[INT_LSB +: INT_W];
            fraction_word_hi_q   <= wr_data[FHI_LSB +: FHI_W];
         end
         if (wr_lsb) fraction_word_lo_q <= wr_data[FLO_LSB +: FLO_W];
         if (wr_rdiv)
         begin
            cycle_slip_reduce_en_q <= wr_data[CSR_BIT];
            cp_set_q     <= wr_data[CP_LSB +: CP_W];
            ref_half_q   <= wr_data[RDIV2_BIT];
            ref_double_q <= wr_data[DBL_BIT];
            r_count_q    <= wr_data[RCNT_LSB +: RCNT_W];
         end
         if (wr_func) polarity_pos_q <= wr_data[POL_BIT];
         if (wr_test)
         begin
            clk_mode_q  <= wr_data[MODE_LSB +: MODE_W];
            timer_val_q <= wr_data[TMR_LSB +: TMR_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // fastlock timer
   // ----------------------------------------------------------------
   // a new int write in fastlock mode restarts the window, so a retune always gets its full time
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fl_q     <= FL_IDLE;
         fl_cnt_q <= '0;
      end
      else if (wr_int && fl_mode)
      begin
         fl_q     <= FL_ARM;
         fl_cnt_q <= timer_val_q;
      end
      else
      begin
         unique case (fl_q)
            FL_IDLE: fl_q <= FL_IDLE;
            FL_ARM:
               if (cmp_tick)
                  fl_q <= (fl_cnt_q == '0) ? FL_IDLE : FL_WIDE;
            FL_WIDE:
               if (cmp_tick)
               begin
                  if (fl_cnt_q <= TMR_W'(1)) fl_q <= FL_IDLE;
                  fl_cnt_q <= fl_cnt_q - TMR_W'(1);
               end
            default: fl_q <= FL_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fraction_word_q     <= '0;
         cp_current_q        <= '0;
         wide_bw_q           <= 1'b0;
         mux_output_pin_o_q  <= 1'b0;
         mux_output_pin_oe_q <= 1'b0;
      end
      else
      begin
         fraction_word_q     <= fraction_word_d;
         cp_current_q        <= cp_d;
         wide_bw_q           <= (fl_q == FL_WIDE);
         mux_output_pin_o_q  <= 1'b0;
         mux_output_pin_oe_q <= fl_pin;
      end
   end

   // ----------------------------------------------------------------
   // slip reduction cells
   // ----------------------------------------------------------------
   fsc_cell_ctrl #(.CELLS(CELLS)) u_cells (
      .clk           (clk),
      .rstn          (rstn),
      .enable        (cycle_slip_reduce_en_q),
      .cmp_tick      (cmp_tick),
      .slip_near     (slip_near),
      .slip_up       (slip_up),
      .passed_target (passed_target),
      .cells_q       (extra_cells_q),
      .dir_up_q      (extra_dir_up_q)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_decode_rdiv;
      @(posedge clk) disable iff (!rstn)
      (wr_strobe && wr_data[CTL_W-1:0] == CTL_RDIV) |=>
         (cycle_slip_reduce_en_q == $past(wr_data[CSR_BIT]));
   endproperty
   a_decode_rdiv: assert property (p_decode_rdiv) else $error("csr bit not taken");

   property p_fraction_word_join;
      @(posedge clk) disable iff (!rstn)
      (wr_strobe && wr_data[CTL_W-1:0] == CTL_LSBFRAC) |=> ##1
         (fraction_word_q[FLO_W-1:0] == $past(wr_data[FLO_LSB +: FLO_W], 2));
   endproperty
   a_fraction_word_join: assert property (p_fraction_word_join) else $error("fraction low wrong");

   property p_no_cells_off;
      @(posedge clk) disable iff (!rstn)
      (!cycle_slip_reduce_en_q && extra_cells_q == '0) |=> (extra_cells_q == '0);
   endproperty
   a_no_cells_off: assert property (p_no_cells_off) else $error("cell while disabled");

   property p_wide_gain;
      @(posedge clk) disable iff (!rstn)
      (fl_q == FL_WIDE && !wr_rdiv) |=>
         (cp_current_q == CPO_W'((CPO_W'(cp_set_q) + CPO_W'(1)) << CP_GAIN_SH));
   endproperty
   a_wide_gain: assert property (p_wide_gain) else $error("wide current wrong");

   property p_arm;
      @(posedge clk) disable iff (!rstn)
      (wr_int && fl_mode) |=> (fl_q == FL_ARM);
   endproperty
   a_arm: assert property (p_arm) else $error("fastlock not armed");

   property p_expire;
      @(posedge clk) disable iff (!rstn)
      (fl_q == FL_WIDE && cmp_tick && fl_cnt_q == TMR_W'(1) && !wr_int) |=>
         (fl_q == FL_IDLE) ##1 (!wide_bw_q && !mux_output_pin_oe_q);
   endproperty
   a_expire: assert property (p_expire) else $error("fastlock did not end");

   property p_count;
      @(posedge clk) disable iff (!rstn)
      (fl_q == FL_WIDE && cmp_tick && !wr_int) |=> (fl_cnt_q == $past(fl_cnt_q) - TMR_W'(1));
   endproperty
   a_count: assert property (p_count) else $error("timer not counting");

   property p_pin;
      @(posedge clk) disable iff (!rstn)
      mux_output_pin_oe_q |-> !mux_output_pin_o_q && $past(mux_sel_q) == MUX_FASTLOCK;
   endproperty
   a_pin: assert property (p_pin) else $error("pin grounded wrongly");

endmodule : fsc_ctrl

// ==== rtl/fsc_pkg.sv ====
// package: constants for the fractional synthesizer control block
package fsc_pkg;

   // ----------------------------------------------------------------
   // serial word layout
   // ----------------------------------------------------------------
   localparam int WORD_W      = 32;
   localparam int CTL_W       = 3;
   localparam logic [2:0] CTL_INTFRAC = 3'h0;
   localparam logic [2:0] CTL_LSBFRAC = 3'h1;
   localparam logic [2:0] CTL_RDIV    = 3'h2;
   localparam logic [2:0] CTL_FUNC    = 3'h3;
   localparam logic [2:0] CTL_TEST    = 3'h4;

   // integer / high fraction register
   localparam int MUX_LSB     = 27;
   localparam int MUX_W       = 4;
   localparam int INT_LSB     = 15;
   localparam int INT_W       = 12;
   localparam int FHI_LSB     = 3;
   localparam int FHI_W       = 12;
   localparam logic [3:0] MUX_FASTLOCK = 4'hC;

   // low fraction register
   localparam int FLO_LSB     = 15;
   localparam int FLO_W       = 13;
   localparam int FRACTION_WORD_W      = 25;

   // reference divider register
   localparam int CSR_BIT     = 28;
   localparam int CP_LSB      = 24;
   localparam int CP_W        = 4;
   localparam int RDIV2_BIT   = 21;
   localparam int DBL_BIT     = 20;
   localparam int RCNT_LSB    = 15;
   localparam int RCNT_W      = 5;

   // function register
   localparam int POL_BIT     = 6;

   // test register
   localparam int MODE_LSB    = 19;
   localparam int MODE_W      = 2;
   localparam int TMR_LSB     = 7;
   localparam int TMR_W       = 12;
   localparam logic [1:0] MODE_FASTLOCK = 2'h1;

   // ----------------------------------------------------------------
   // slip reduction and fastlock
   // ----------------------------------------------------------------
   localparam int CELL_W      = 3;
   localparam logic [2:0] CELL_MAX = 3'h7;
   localparam int CP_GAIN_SH  = 4;   // x16 in wide bandwidth
   localparam int CPO_W       = CP_W + CP_GAIN_SH + 1;

   typedef enum logic [1:0] {
      FL_IDLE = 2'b00,
      FL_ARM  = 2'b01,
      FL_WIDE = 2'b11
   } fsc_fl_e;

endpackage : fsc_pkg

// ==== tb/fraction_word_synth_fastlock_csr_ctrl_test.sv ====
// self-checking testbench for the synthesizer control block
`timescale 1ns/1ps
module fraction_word_synth_fastlock_csr_ctrl_test;
   import fsc_pkg::*;

   logic                clk, rstn, cmp_tick, slip_near, slip_up, passed_target;
   logic [WORD_W-1:0]   wr_data;
   logic                wr_strobe;
   logic [INT_W-1:0]    int_value_q;
   logic [FRACTION_WORD_W-1:0]   fraction_word_q;
   logic                ref_double_q, ref_half_q, polarity_pos_q, wide_bw_q;
   logic [RCNT_W-1:0]   r_count_q;
   logic [CPO_W-1:0]    cp_current_q;
   logic                cycle_slip_reduce_en_q, extra_dir_up_q, mux_output_pin_oe_q;
   logic                mux_output_pin_o_q;
   logic [CELL_W-1:0]   extra_cells_q;
   logic [MUX_W-1:0]    mux_sel_q;
   int                  fail_count = 0;
   int                  checks = 0;
   int                  seed = 32'h1E466EB8;
   int                  sel_q[$];
   logic [31:0]         exp_q[$];
   event                obs;
   logic [11:0]         iv, hi;
   logic [12:0]         lo;
   logic [3:0]          cp, mux;
   logic [4:0]          rc;
   logic                dbl;
   int                  k, n;
   logic [11:0]         tmr_tab[3] = '{12'h005, 12'h000, 12'h003};
   logic [3:0]          mux_tab[3] = '{4'hC, 4'hC, 4'h5};

   fsc_host_model host (.clk(clk), .wr_data(wr_data), .wr_strobe(wr_strobe));

   fsc_ctrl #(.CELLS(7)) DUT (
      .clk(clk), .rstn(rstn), .wr_data(wr_data), .wr_strobe(wr_strobe),
      .cmp_tick(cmp_tick), .slip_near(slip_near), .slip_up(slip_up),
      .passed_target(passed_target), .int_value_q(int_value_q),
      .fraction_word_q(fraction_word_q), .ref_double_q(ref_double_q),
      .r_count_q(r_count_q), .ref_half_q(ref_half_q), .polarity_pos_q(polarity_pos_q),
      .cp_current_q(cp_current_q), .wide_bw_q(wide_bw_q),
      .cycle_slip_reduce_en_q(cycle_slip_reduce_en_q), .extra_cells_q(extra_cells_q),
      .extra_dir_up_q(extra_dir_up_q), .mux_sel_q(mux_sel_q),
      .mux_output_pin_o_q(mux_output_pin_o_q), .mux_output_pin_oe_q(mux_output_pin_oe_q));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] pick(input int sel);
      case (sel)
         0: pick = 32'(int_value_q);
         1: pick = 32'(fraction_word_q);
         2: pick = 32'(ref_double_q);
         3: pick = 32'(r_count_q);
         4: pick = 32'(ref_half_q);
         6: pick = 32'(cp_current_q);
         7: pick = 32'(wide_bw_q);
         8: pick = 32'(cycle_slip_reduce_en_q);
         9: pick = 32'(extra_cells_q);
         10: pick = 32'(extra_dir_up_q);
         11: pick = 32'(mux_sel_q);
         12: pick = 32'(mux_output_pin_oe_q);
         13: pick = 32'(mux_output_pin_o_q);
         default: pick = 32'(polarity_pos_q);
      endcase
   endfunction : pick

   task automatic compare(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : compare

   task automatic note(input int sel, input logic [31:0] want);
      sel_q.push_back(sel);
      exp_q.push_back(want);
   endtask : note

   task automatic flush;
      -> obs;
      #1;
   endtask : flush

   // field and pump registers trail the strobe by up to two edges
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic tick(input logic near);
      @(posedge clk);
      #1;
      cmp_tick  = 1'b1;
      slip_near = near;
      @(posedge clk);
      #1;
      cmp_tick  = 1'b0;
      slip_near = 1'b0;
      settle();
   endtask : tick

   task automatic finish_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // output watcher
   // ----------------------------------------------------------------
   always @(obs)
   begin : watch
      int s;
      while (sel_q.size() > 0)
      begin
         s = sel_q.pop_front();
         compare(pick(s), exp_q.pop_front());
      end
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("wrong value at %0t: run did not complete", $time);
      finish_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rstn = 1'b0; cmp_tick = 1'b0; slip_near = 1'b0; slip_up = 1'b0; passed_target = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      settle();
      // pump shows one unit for its zero setting from the first edge on
      for (k = 0; k < 14; k++) note(k, (k == 6) ? 32'h1 : 32'h0);
      flush();
      for (k = 0; k < 3; k++)
      begin
         iv = $random(seed); hi = $random(seed); lo = $random(seed); cp = $random(seed);
         rc = $random(seed); dbl = $random(seed); mux = $random(seed);
         host.gap = k;
         host.init_seq(iv, hi, lo, cp, rc, dbl, k[0], mux, 2'b00, 12'h000);
         settle();
         note(0, 32'(iv));
         note(1, (32'(hi) << 13) | 32'(lo));
         note(2, 32'(dbl));
         note(3, 32'(rc));
         note(4, 32'(k[0]));
         note(6, 32'(cp) + 32'h1);
         note(8, 32'(k[0]));
         note(11, 32'(mux));
         note(12, 32'h0);
         note(13, 32'h0);
         note(5, 32'h1);
         flush();
      end
      for (k = 5; k < 8; k++) host.write_word({29'h1FFFFFFF, 3'(k)});
      settle();
      note(0, 32'(iv));
      note(1, (32'(hi) << 13) | 32'(lo));
      note(6, 32'(cp) + 32'h1);
      flush();
      for (k = 0; k < 3; k++)
      begin
         host.init_seq(iv, hi, lo, cp, rc, dbl, 1'b0, mux_tab[k], MODE_FASTLOCK, tmr_tab[k]);
         settle();
         note(7, 32'h0);
         flush();
         for (n = 1; n <= 32'(tmr_tab[k]) + 1; n++)
         begin
            tick(1'b0);
            note(7, 32'(n <= tmr_tab[k]));
            note(12, 32'(n <= tmr_tab[k] && mux_tab[k] == MUX_FASTLOCK));
            note(13, 32'h0);
            note(6, (n <= tmr_tab[k]) ? (32'(cp) + 32'h1) << 4 : 32'(cp) + 32'h1);
            flush();
         end
      end
      slip_up = $random(seed);
      host.init_seq(iv, hi, lo, cp, rc, dbl, 1'b1, mux, 2'b00, 12'h000);
      for (n = 1; n <= 9; n++)
      begin
         tick(1'b1);
         note(9, 32'((n < 7) ? n : 7));
         note(10, 32'(slip_up));
         flush();
      end
      @(posedge clk);
      #1;
      passed_target = 1'b1;
      @(posedge clk);
      #1;
      passed_target = 1'b0;
      for (n = 6; n >= 0; n--)
      begin
         tick(1'b0);
         note(9, 32'(n));
         flush();
      end
      host.init_seq(iv, hi, lo, cp, rc, dbl, 1'b0, mux, 2'b00, 12'h000);
      tick(1'b1);
      note(9, 32'h0);
      flush();
      finish_test();
   end

endmodule : fraction_word_synth_fastlock_csr_ctrl_test

// ==== tb/fsc_host_model.sv ====
// host controller model that programs the synthesizer control registers
`timescale 1ns/1ps
module fsc_host_model
   import fsc_pkg::*;
(
   // clock
   input  wire logic              clk,
   // latched serial word towards the block
   output logic [WORD_W-1:0]      wr_data,
   output logic                   wr_strobe
);
   // extra idle cycles before each word, raised to mimic a slow host
   int gap = 0;

   initial
   begin
      wr_data   = '0;
      wr_strobe = 1'b0;
   end

   // ----------------------------------------------------------------
   // one latched word
   // ----------------------------------------------------------------
   task automatic write_word(input logic [WORD_W-1:0] w);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      #1;
      wr_data   = w;
      wr_strobe = 1'b1;
      @(posedge clk);
      #1;
      wr_strobe = 1'b0;
      // stale word is inverted so nothing can lean on a held value
      wr_data   = ~w;
   endtask : write_word

   // ----------------------------------------------------------------
   // full programming pass, int word always last
   // ----------------------------------------------------------------
   task automatic init_seq(input logic [11:0] iv, input logic [11:0] hi,
                           input logic [12:0] lo, input logic [3:0] cp,
                           input logic [4:0] rc, input logic dbl, input logic slip_en,
                           input logic [3:0] mux, input logic [1:0] mode,
                           input logic [11:0] tmr);
      write_word((32'(mode) << MODE_LSB) | (32'(tmr) << TMR_LSB) | 32'(CTL_TEST));
      // positive polarity always, so slip reduction stays legal
      write_word((32'h1 << POL_BIT) | 32'(CTL_FUNC));
      // reference assumed at most 16 MHz, so even doubled the rate stays low;
      // half rate stage goes on with slip reduction for an even duty
      write_word((32'(slip_en) << CSR_BIT) | (32'(cp) << CP_LSB) | (32'(slip_en) << RDIV2_BIT)
                 | (32'(dbl) << DBL_BIT) | (32'(rc) << RCNT_LSB) | 32'(CTL_RDIV));
      write_word((32'(lo) << FLO_LSB) | 32'(CTL_LSBFRAC));
      write_word((32'(mux) << MUX_LSB) | (32'(iv) << INT_LSB) | (32'(hi) << FHI_LSB)
                 | 32'(CTL_INTFRAC));
   endtask : init_seq

endmodule : fsc_host_model
